// ### dv/fcs_monitor.sv
// Port checker for the fractional clock synthesizer.
`timescale 1ns/1ps
`default_nettype none
module fcs_monitor #(
  parameter NUMERATOR    = 4,       // Ratio numerator.
  parameter DENOMINATOR  = 1,       // Ratio denominator.
  parameter RANGE_SELECT = 0,       // Output band select.
  parameter PW           = 16,      // Period count width.
  parameter OUT_HALF     = 20       // Expected output half period.
) (
  input  wire logic        i_clk,                      // System clock.
  input  wire logic        i_arst_n,                   // Reset, low.
  input  wire logic        i_ref_clock_in,             // Reference level.
  input  wire logic [3:0]  i_addr,                     // Register address.
  input  wire logic [31:0] i_wr_data,                  // Write data.
  input  wire logic        i_wr_en,                    // Write strobe.
  input  wire logic        i_rd_en,                    // Read strobe.
  input  wire logic [31:0] o_rd_data,                  // Read data.
  input  wire logic        o_synth_clock_out,          // Synthesized clock.
  input  wire logic        o_synth_clock_out_inverted, // Shifted copy.
  input  wire logic        o_locked                    // Lock indicator.
);
  localparam logic [5:0] N6 = NUMERATOR;    // Numerator field.
  localparam logic [5:0] D6 = DENOMINATOR;  // Denominator field.
  localparam logic       R1 = RANGE_SELECT; // Range bit.
  logic        out_q;      // Output level one cycle earlier.
  logic [7:0]  run_cnt;    // Cycles since the output last changed.
  logic [7:0]  lock_age;   // Cycles since lock, saturating.
  logic        ref_q;      // Reference level one cycle earlier.
  logic [31:0] ref_quiet;  // Cycles since the reference last moved.
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  // Run lengths and ages; lock_age keeps the duty check off the first
  // runs, which may have begun before the lock was declared.
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      out_q     <= 1'b0;
      run_cnt   <= 8'h00;
      lock_age  <= 8'h00;
      ref_q     <= 1'b0;
      ref_quiet <= 32'h0;
    end else begin
      out_q     <= o_synth_clock_out;
      run_cnt   <= (o_synth_clock_out != out_q) ? 8'h00 : run_cnt + 8'h01;
      lock_age  <= !o_locked ? 8'h00 : lock_age + {7'h0, lock_age != 8'hFF};
      ref_q     <= i_ref_clock_in;
      ref_quiet <= (i_ref_clock_in != ref_q) ? 32'h0 : ref_quiet + 32'h1;
    end
  end
  a_reset_quiet: assert property ($rose(i_arst_n) |-> !o_locked &&
    !o_synth_clock_out && !o_synth_clock_out_inverted)
    else $error("outputs not quiet after reset");
  a_lock_aligned: assert property ($rose(o_locked) |-> o_synth_clock_out
    && $past(i_ref_clock_in, 2) && !$past(i_ref_clock_in, 3))
    else $error("lock raised off a coincidence edge");
  a_inv_phase: assert property (o_locked |->
    o_synth_clock_out_inverted == !o_synth_clock_out)
    else $error("inverted output not opposite the main output");
  a_even_duty: assert property (o_locked && lock_age > 8'd45 &&
    o_synth_clock_out != out_q |-> run_cnt == OUT_HALF - 1)
    else $error("output level held for the wrong span");
  a_cfg_read: assert property ($past(i_rd_en) && $past(i_addr) == 4'hC
    |-> o_rd_data == {15'h0, R1, 2'h0, D6, 2'h0, N6})
    else $error("configuration word wrong");
  a_stat_read: assert property ($past(i_rd_en) && $past(i_addr) == 4'h4
    |-> o_rd_data[0] == $past(o_locked) && o_rd_data[31:3] == 29'h0)
    else $error("status word wrong");
  a_rd_idle: assert property (!$past(i_rd_en) |-> o_rd_data == 32'h0)
    else $error("read data outside its slot");
  a_dead_ref: assert property (ref_quiet > 2 ** PW + 8 |->
    !o_locked && !o_synth_clock_out)
    else $error("lock kept on a dead reference");
  a_off_quiet: assert property (i_wr_en && i_addr == 4'h0 && !i_wr_data[0]
    |-> ##3 !o_locked && !o_synth_clock_out)
    else $error("outputs still running after disable");
endmodule
bind fractional_clock_synth fcs_monitor #(.NUMERATOR(NUMERATOR),
  .DENOMINATOR(DENOMINATOR), .RANGE_SELECT(RANGE_SELECT), .PW(PW))
  fcs_monitor_inst (.i_clk(i_clk), .i_arst_n(i_arst_n),
  .i_ref_clock_in(i_ref_clock_in), .i_addr(i_addr), .i_wr_data(i_wr_data),
  .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .o_rd_data(o_rd_data),
  .o_synth_clock_out(o_synth_clock_out),
  .o_synth_clock_out_inverted(o_synth_clock_out_inverted),
  .o_locked(o_locked));
`default_nettype wire

// ### dv/fractional_clock_synth_bench.sv
// Self-checking bench: register reads, lock, output shape and restarts.
`timescale 1ns/1ps
`default_nettype none
`include "fractional_clock_synth_consts.vh"
`define CHK(g, e) chk_val(32'(g), 32'(e))
module fractional_clock_synth_bench;
  localparam NUM = 3;          // Reduced ratio 3/2 locks soonest.
  localparam DEN = 2;          // Coincidence every two reference cycles.
  logic        i_clk = 1'b0;   // System clock, 200 MHz.
  logic        i_arst_n = 1'b0; // Reset, low.
  logic        ref_run = 1'b1; // Source running.
  logic [3:0]  i_addr = 4'h0;  // Register address.
  logic [31:0] i_wr_data = 32'h0; // Write data.
  logic        i_wr_en = 1'b0; // Write strobe.
  logic        i_rd_en = 1'b0; // Read strobe.
  wire  [31:0] o_rd_data;      // Read data.
  wire         synth, inv, locked, refc; // Clocks, lock, reference.
  int          fails = 0, num_checks = 0; // Mismatches and comparisons.
  logic [31:0] d;              // Last read word.
  always #2.5 i_clk = ~i_clk;
  // Reference period 60 cycles, so output period is 60*2/3 = 40.
  ref_clock_source #(.HALF(30)) ref_clock_source_inst (.i_clk(i_clk),
    .i_run(ref_run), .o_ref(refc));
  // Ratio and band fixed at build; low band suits the slow output.
  fractional_clock_synth #(.NUMERATOR(NUM), .DENOMINATOR(DEN),
    .RANGE_SELECT(`FCS_RANGE_LOW), .PW(10)) fractional_clock_synth_inst (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_ref_clock_in(refc),
    .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr_en(i_wr_en),
    .i_rd_en(i_rd_en), .o_rd_data(o_rd_data), .o_synth_clock_out(synth),
    .o_synth_clock_out_inverted(inv), .o_locked(locked));
  task chk_val(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("wrong value at %0t ns: got %h expected %h", $time, g, e);
    end
  endtask
  task results;
    if (fails == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge i_clk);
    i_addr <= a; i_wr_data <= v; i_wr_en <= 1'b1;
    @(posedge i_clk);
    i_wr_en <= 1'b0;
  endtask
  // Data stand only in the cycle after the strobe; sample there.
  task rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge i_clk);
    i_addr <= a; i_rd_en <= 1'b1;
    @(posedge i_clk);
    i_rd_en <= 1'b0;
    #1 v = o_rd_data;
  endtask
  // Bounded wait; lock needs a handful of reference periods.
  task wait_lock;
    int n;
    n = 0;
    while (locked !== 1'b1 && n < 3000) begin
      @(posedge i_clk);
      n++;
    end
    #1 `CHK(locked, 1'b1);
  endtask
  // Over 240 cycles (four reference periods) count rises, high cycles,
  // phase faults and rises landing two cycles after a reference rise.
  task measure;
    int rises, highs, bad, coin;
    logic [3:0] rh;
    logic oq;
    rises = 0; highs = 0; bad = 0; coin = 0; rh = 4'h0; oq = synth;
    repeat (240) begin
      rh = {rh[2:0], refc};
      @(posedge i_clk);
      #1;
      if (synth === 1'b1 && oq === 1'b0) begin
        rises++;
        if (rh[1] && !rh[2]) coin++;
      end
      if (synth === 1'b1) highs++;
      if (inv !== ~synth) bad++;
      oq = synth;
    end
    `CHK(rises, 240 * NUM / (60 * DEN));
    `CHK(highs, 120);
    `CHK(bad, 0);
    `CHK(coin, 240 / (60 * DEN));
  endtask
  initial begin
    repeat (20000) @(posedge i_clk);
    fails++;
    results;
  end
  initial begin
    repeat (4) @(posedge i_clk);
    i_arst_n <= 1'b1;
    rd(`FCS_ADDR_STATUS, d); `CHK(d, 32'h0);
    rd(`FCS_ADDR_CTRL, d); `CHK(d, 32'h1);
    rd(`FCS_ADDR_CONFIG, d); `CHK(d, 32'h00000203);
    rd(4'h2, d); `CHK(d, 32'h0);
    wr(`FCS_ADDR_STATUS, 32'h0);
    rd(`FCS_ADDR_CTRL, d); `CHK(d, 32'h1);
    wait_lock;
    rd(`FCS_ADDR_STATUS, d); `CHK(d, 32'h7);
    rd(`FCS_ADDR_PERIOD, d); `CHK(d, 32'd60);
    measure;
    wr(`FCS_ADDR_CTRL, 32'h0);
    repeat (3) @(posedge i_clk);
    #1 `CHK({locked, synth, inv}, 3'h0);
    wr(`FCS_ADDR_CTRL, 32'h1);
    wait_lock;
    wr(`FCS_ADDR_CTRL, 32'h3);
    repeat (3) @(posedge i_clk);
    #1 `CHK(locked, 1'b0);
    rd(`FCS_ADDR_CTRL, d); `CHK(d, 32'h1);
    wait_lock;
    measure;
    ref_run <= 1'b0;
    repeat (1100) @(posedge i_clk);
    rd(`FCS_ADDR_STATUS, d); `CHK(d, 32'h0);
    `CHK(synth, 1'b0);
    ref_run <= 1'b1;
    wait_lock;
    @(posedge i_clk);
    i_arst_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    #1 `CHK({locked, synth, inv}, 3'h0);
    @(posedge i_clk);
    i_arst_n <= 1'b1;
    rd(`FCS_ADDR_STATUS, d); `CHK(d, 32'h0);
    wait_lock;
    measure;
    results;
  end
endmodule
`default_nettype wire

// ### dv/ref_clock_source.sv
// External reference clock source that feeds the synthesizer under test.
`timescale 1ns/1ps
`default_nettype none
module ref_clock_source #(
  parameter HALF = 30               // Half period in system clock cycles.
) (
  input  wire logic i_clk,          // System clock.
  input  wire logic i_run,          // Low parks the reference low.
  output var  logic o_ref           // Reference clock level.
);
  int cnt = 0;                      // Cycles into the current half period.
  initial o_ref = 1'b0;
  // Square wave of 2*HALF system cycles, well inside the input band.
  // A stopped source parks low, as a dead oscillator would.
  always @(posedge i_clk) begin
    if (!i_run) begin
      cnt   <= 0;
      o_ref <= 1'b0;
    end else if (cnt == HALF - 1) begin
      cnt   <= 0;
      o_ref <= ~o_ref;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule
`default_nettype wire

// ### rtl/fractional_clock_synth.v
// Fractional clock synthesizer with lock detection and register port.
//
// Behaviour
// - Output frequency is reference times numerator over denominator.
// - Inverted output, same frequency, half period shifted.
// - Both outputs keep fifty percent duty cycle; here only when the window span is a multiple of twice the numerator.
// - Ratio applied at once, no multiplied intermediate.
// - Loop feedback taken internally from the reference.
// - Rising edges coincide every denominator reference cycles.
// - After lock, realign at every coincidence point.
// - Lock asserted only once outputs are aligned.
//
// Our own choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "fractional_clock_synth_consts.vh"

module fractional_clock_synth #(
  parameter NUMERATOR    = `FCS_NUM_DEFAULT,  // Ratio numerator.
  parameter DENOMINATOR  = `FCS_DEN_DEFAULT,  // Ratio denominator.
  parameter RANGE_SELECT = `FCS_RANGE_LOW,    // Output band select.
  parameter PW           = 16,                // Period count width.
  parameter AW           = 24                 // Phase accumulator width.
) (
  input  wire        i_clk,                   // System clock, 200 MHz.
  input  wire        i_arst_n,                // Asynchronous reset, low.
  input  wire        i_ref_clock_in,          // Reference clock level.
  input  wire [3:0]  i_addr,                  // Register byte address.
  input  wire [31:0] i_wr_data,               // Register write data.
  input  wire        i_wr_en,                 // Write strobe.
  input  wire        i_rd_en,                 // Read strobe.
  output reg  [31:0] o_rd_data,               // Read data, next cycle.
  output reg         o_synth_clock_out,       // Synthesized clock.
  output reg         o_synth_clock_out_inverted, // Shifted copy.
  output reg         o_locked                 // Lock indicator.
);

  // The ratio and band are parameters only; software can read them but
  // has no way to change them while running.
  // Wide copies come first so that every narrower constant below is cut
  // on purpose by a part-select rather than by silent truncation.
  localparam [31:0]   NUM32  = NUMERATOR;       // Numerator, full width.
  localparam [31:0]   DEN32  = DENOMINATOR;     // Denominator, full width.
  localparam [31:0]   DEN_M1 = DENOMINATOR - 1; // Last edge index, wide.
  localparam [31:0]   STEP32 = 2 * NUMERATOR;   // Accumulator step, wide.
  localparam [5:0]    NUM6  = NUM32[5:0];     // Numerator for readback.
  localparam [5:0]    DEN6  = DEN32[5:0];     // Denominator for readback.
  localparam [5:0]    DEN_LAST = DEN_M1[5:0]; // Last edge index.
  localparam [AW-1:0] STEP  = STEP32[AW-1:0]; // Half periods per window.
  localparam [AW-1:0] DEN_W = DEN32[AW-1:0];  // Denominator, wide.
  localparam [AW-1:0] ZERO_A = {AW{1'b0}};    // Accumulator clear value.
  localparam [5:0]    ONE6  = 6'h01;          // Edge counter step.
  localparam          RANGE_BIT = RANGE_SELECT; // Band bit for readback.

  // Lock sequence: idle waits for a coincidence edge with a valid period,
  // acquire runs one whole window and checks that every reference edge
  // in it kept the same period, and lock realigns at every coincidence.
  // A reduced ratio gives a shorter window and therefore a faster lock.
  // One-hot controller states.
  localparam [2:0] ST_IDLE = 3'h1;            // Outputs parked low.
  localparam [2:0] ST_ACQ  = 3'h2;            // Running, not yet locked.
  localparam [2:0] ST_LOCK = 3'h4;            // Locked and realigning.

  // Window length in system cycles: one coincidence interval spans the
  // denominator count of reference periods.
  function [AW-1:0] window_span;
    input [PW-1:0] period;
    begin
      window_span = {{(AW-PW){1'b0}}, period} * DEN_W;
    end
  endfunction

  // One accumulator step, shared by the acquiring and locked states: the
  // top bit says the sum reached the span and the output must toggle;
  // the rest is the carried remainder, which keeps the long-run ratio
  // exact even when the span is not a multiple of the step.
  function [AW:0] dda_advance;
    input [AW-1:0] sum;
    input [AW-1:0] lim;
    begin
      if (sum >= lim) begin
        dda_advance = {1'b1, sum - lim};
      end else begin
        dda_advance = {1'b0, sum};
      end
    end
  endfunction

  // Reference period measurement.
  wire          ref_edge;                     // Rising reference edge.
  wire [PW-1:0] ref_period;                   // Period in system cycles.
  wire          ref_valid;                    // Period is meaningful.
  wire          ref_stable;                   // Period did not move.

  // The reference itself is the only feedback; no external return path
  // is needed or offered.
  ref_period_meter #(
    .PW       (PW)
  ) ref_period_meter_inst (
    .i_clk    (i_clk),
    .i_arst_n (i_arst_n),
    .i_ref    (i_ref_clock_in),
    .o_edge   (ref_edge),
    .o_period (ref_period),
    .o_valid  (ref_valid),
    .o_stable (ref_stable)
  );

  // The meter also times out a dead reference, which drops lock.
  // Control and internal state.
  reg          ctrl_en;                       // Synthesizer enable.
  reg          relock;                        // One-cycle relock request.
  reg [2:0]    state;                         // Controller state.
  reg [2:0]    next_state;                    // Next controller state.
  reg [5:0]    edge_idx;                      // Reference edge index.
  reg [AW-1:0] acc;                           // Phase accumulator.
  reg          win_ok;                        // Window stayed stable.
  reg          next_out;                      // Next output level.
  reg [AW-1:0] next_acc;                      // Next accumulator value.
  reg          next_win_ok;                   // Next window flag.
  reg          next_locked;                   // Next lock indicator.

  wire [AW-1:0] span    = window_span(ref_period); // Cycles per window.
  wire [AW-1:0] acc_sum = acc + STEP;         // Accumulator after step.
  wire [AW:0]   adv     = dda_advance(acc_sum, span); // Toggle and rest.
  wire          coincide = ref_edge & (edge_idx == DEN_LAST);

  // Register writes. Relock is a strobe bit that clears itself, so a
  // write of one simply restarts acquisition.
  // Writes to any other address are ignored.
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctrl_en <= `FCS_CTRL_EN_RESET;
      relock  <= 1'b0;
    end else begin
      relock <= 1'b0;
      if (i_wr_en && (i_addr == `FCS_ADDR_CTRL)) begin
        ctrl_en <= i_wr_data[`FCS_CTRL_EN_BIT];
        relock  <= i_wr_data[`FCS_CTRL_RELOCK_BIT];
      end
    end
  end

  // Register reads answer in the following cycle only; unmapped
  // addresses and idle cycles return zero.
  // Reads have no side effects, so status may be polled freely.
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rd_data <= 32'h0000_0000;
    end else begin
      o_rd_data <= 32'h0000_0000;
      if (i_rd_en) begin
        case (i_addr)
          `FCS_ADDR_CTRL: begin
            o_rd_data[`FCS_CTRL_EN_BIT] <= ctrl_en;
          end
          `FCS_ADDR_STATUS: begin
            o_rd_data[`FCS_STAT_LOCK_BIT]   <= o_locked;
            o_rd_data[`FCS_STAT_VALID_BIT]  <= ref_valid;
            o_rd_data[`FCS_STAT_STABLE_BIT] <= ref_stable;
          end
          `FCS_ADDR_PERIOD: begin
            o_rd_data[PW-1:0] <= ref_period;
          end
          `FCS_ADDR_CONFIG: begin
            o_rd_data[`FCS_CFG_NUM_LSB+5:`FCS_CFG_NUM_LSB] <= NUM6;
            o_rd_data[`FCS_CFG_DEN_LSB+5:`FCS_CFG_DEN_LSB] <= DEN6;
            o_rd_data[`FCS_CFG_RANGE_BIT] <= RANGE_BIT;
          end
          default: begin
            o_rd_data <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

  // Reference edge index. It wraps after the denominator count, so the
  // wrap marks the coincidence point of reference and output edges.
  // Counting starts afresh whenever the period turns valid again, so a
  // restarted reference picks a new coincidence phase.
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      edge_idx <= 6'h00;
    end else if (!ref_valid) begin
      edge_idx <= 6'h00;
    end else if (ref_edge) begin
      edge_idx <= (edge_idx == DEN_LAST) ? 6'h00 : edge_idx + ONE6;
    end
  end

  // Controller and phase accumulator. Each system cycle adds twice the
  // numerator; each time the sum passes the window span the output
  // toggles. Over one window exactly twice the numerator toggles occur,
  // spaced as evenly as the system clock allows, which gives the ratio
  // directly without any multiplied intermediate clock.
  // Limitation: toggles are quantised to the 5 ns system clock, so the
  // output cannot exceed half the system rate and carries one cycle of
  // edge jitter. The band parameters only matter to the analog original.
  always @* begin
    next_state  = state;
    next_out    = o_synth_clock_out;
    next_acc    = acc;
    next_win_ok = win_ok;
    next_locked = o_locked;
    case (state)
      ST_IDLE: begin
        // Park low; start cleanly on a coincidence edge.
        next_out    = 1'b0;
        next_acc    = ZERO_A;
        next_locked = 1'b0;
        if (ctrl_en && ref_valid && coincide) begin
          next_out    = 1'b1;
          next_win_ok = 1'b1;
          next_state  = ST_ACQ;
        end
      end
      ST_ACQ: begin
        // Free-running; no realignment happens before lock.
        if (adv[AW]) begin
          next_out = ~o_synth_clock_out;
        end
        next_acc = adv[AW-1:0];
        if (ref_edge && !ref_stable) begin
          next_win_ok = 1'b0;
        end
        if (coincide) begin
          if (win_ok && ref_stable) begin
            // Align at this very edge and only then report lock.
            next_out    = 1'b1;
            next_acc    = ZERO_A;
            next_locked = 1'b1;
            next_state  = ST_LOCK;
          end else begin
            next_win_ok = 1'b1;
          end
        end
      end
      ST_LOCK: begin
        // Same step as while acquiring, plus realignment below.
        if (adv[AW]) begin
          next_out = ~o_synth_clock_out;
        end
        next_acc = adv[AW-1:0];
        if (ref_edge && !ref_stable) begin
          // Reference moved: drop lock and acquire again.
          next_locked = 1'b0;
          next_out    = 1'b0;
          next_state  = ST_IDLE;
        end else if (coincide) begin
          // Realign so phase error at coincidence is one cycle at most.
          next_out = 1'b1;
          next_acc = ZERO_A;
        end
      end
      default: begin
        // Unreachable with one-hot codes; recover to a parked idle.
        next_state  = ST_IDLE;
        next_out    = 1'b0;
        next_acc    = ZERO_A;
        next_locked = 1'b0;
      end
    endcase
    // Disable, relock or a lost reference always fall back to idle.
    if (!ctrl_en || relock || !ref_valid) begin
      next_state  = ST_IDLE;
      next_out    = 1'b0;
      next_acc    = ZERO_A;
      next_locked = 1'b0;
    end
  end

  // State registers. The inverted output is the complement of the next
  // main level, registered in the same edge, so it is exactly half a
  // period shifted while both keep the same duty cycle. When idle both
  // outputs park low instead, so a stopped clock never looks inverted.
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state                      <= ST_IDLE;
      acc                        <= {AW{1'b0}};
      win_ok                     <= 1'b0;
      o_synth_clock_out          <= 1'b0;
      o_synth_clock_out_inverted <= 1'b0;
      o_locked                   <= 1'b0;
    end else begin
      state             <= next_state;
      acc               <= next_acc;
      win_ok            <= next_win_ok;
      o_synth_clock_out <= next_out;
      o_locked          <= next_locked;
      if (next_state == ST_IDLE) begin
        o_synth_clock_out_inverted <= 1'b0;
      end else begin
        o_synth_clock_out_inverted <= ~next_out;
      end
    end
  end

endmodule
`default_nettype wire

// ### rtl/fractional_clock_synth_consts.vh
// Constants shared by the fractional clock synthesizer and its period meter.
`ifndef FRACTIONAL_CLOCK_SYNTH_CONSTS_VH
`define FRACTIONAL_CLOCK_SYNTH_CONSTS_VH

// Register byte addresses on the plain register port.
`define FCS_ADDR_CTRL      4'h0
`define FCS_ADDR_STATUS    4'h4
`define FCS_ADDR_PERIOD    4'h8
`define FCS_ADDR_CONFIG    4'hC

// Control register fields.
`define FCS_CTRL_EN_BIT    0
`define FCS_CTRL_RELOCK_BIT 1
`define FCS_CTRL_EN_RESET  1'h1

// Status register fields.
`define FCS_STAT_LOCK_BIT   0
`define FCS_STAT_VALID_BIT  1
`define FCS_STAT_STABLE_BIT 2

// Configuration register field positions (read only).
`define FCS_CFG_NUM_LSB    0
`define FCS_CFG_DEN_LSB    8
`define FCS_CFG_RANGE_BIT  16

// Defaults of the design-time ratio and range.
`define FCS_NUM_DEFAULT    4
`define FCS_DEN_DEFAULT    1
`define FCS_RANGE_LOW      1'h0
`define FCS_RANGE_HIGH     1'h1

// Period meter tolerance in system clock cycles.
`define FCS_PERIOD_TOL     1

`endif

// ### rtl/ref_period_meter.v
// Reference edge detector and period meter in system clock cycles.
`timescale 1ns/1ps
`default_nettype none
`include "fractional_clock_synth_consts.vh"

module ref_period_meter #(
  parameter PW = 16                          // Width of the period count.
) (
  input  wire          i_clk,                // System clock.
  input  wire          i_arst_n,             // Asynchronous reset, low.
  input  wire          i_ref,                // Reference level, synchronous.
  output reg           o_edge,               // Pulse on each rising edge.
  output reg  [PW-1:0] o_period,             // Last measured period.
  output reg           o_valid,              // Period is meaningful.
  output reg           o_stable              // Last two periods agree.
);

  localparam [PW-1:0] ONE  = 1;                // Count restart value.
  localparam [PW-1:0] TOL  = `FCS_PERIOD_TOL;  // Allowed period wobble.
  localparam [PW-1:0] SATV = {PW{1'b1}};       // Timeout, reference lost.

  reg          ref_d;                        // Previous reference level.
  reg [PW-1:0] cnt;                          // Cycles since last edge.
  reg          seen;                         // At least one edge seen.
  wire         rise = i_ref & ~ref_d;        // Rising edge this cycle.
  wire [PW-1:0] diff = (cnt > o_period) ? (cnt - o_period)
                                        : (o_period - cnt);

  // Each rising edge closes one period; a saturated count means the
  // reference has stopped, so the period is declared invalid.
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ref_d    <= 1'b0;
      cnt      <= {PW{1'b0}};
      seen     <= 1'b0;
      o_edge   <= 1'b0;
      o_period <= {PW{1'b0}};
      o_valid  <= 1'b0;
      o_stable <= 1'b0;
    end else begin
      ref_d  <= i_ref;
      o_edge <= rise;
      if (rise) begin
        // Period closes; stability compares against the one before.
        cnt      <= ONE;
        seen     <= 1'b1;
        o_period <= cnt;
        o_valid  <= seen;
        o_stable <= seen & o_valid & (diff <= TOL);
      end else if (cnt == SATV) begin
        // Reference lost: clear seen, valid and stable until edges return; the period keeps its value.
        seen     <= 1'b0;
        o_valid  <= 1'b0;
        o_stable <= 1'b0;
      end else begin
        cnt <= cnt + ONE;
      end
    end
  end

endmodule
`default_nettype wire
